/* rpmc_pkg.sv */
package rpmc_pkg;
  // Register map
  localparam logic [7:0] REG_MASK   = 8'h02;
  localparam logic [7:0] REG_PER_HI = 8'h05;
  localparam logic [7:0] REG_PER_LO = 8'h06;
  localparam logic [7:0] REG_CTRL   = 8'h07;
  // Values after reset
  localparam logic [7:0] MASK_RST   = 8'h18;
  localparam logic [7:0] CTRL_RST   = 8'h44;
  localparam logic [5:0] HI_RSV_RST = 6'h00;
  localparam logic [9:0] PER_RST    = 10'h000;
  // Control field positions
  localparam int CTRL_GC_BIT   = 7;
  localparam int CTRL_AVG_BIT  = 6;
  localparam int CTRL_COMP_LSB = 4;
  localparam int CTRL_FUNC_LSB = 2;
  localparam int CTRL_MODE_LSB = 0;
  // Bus constants
  localparam logic [6:0] GROUP_ADDR    = 7'h58;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Period time step in ns and clock period in ns
  localparam int PERIOD_STEP_NS = 24390;
  localparam int CLK_PERIOD_NS  = 5;
  localparam logic [15:0] STEP_NS_W = 16'(PERIOD_STEP_NS);
  localparam logic [15:0] CLK_NS_W  = 16'(CLK_PERIOD_NS);
  localparam int STEP_CYCLES = PERIOD_STEP_NS / CLK_PERIOD_NS;
  localparam int AVG_DEPTH = 4;
  localparam int AVG_SHIFT = 2;
  localparam logic [9:0] PER_MAX = 10'h3ff;
  // Compensation factor in percent
  localparam logic [2:0] COMP_PCT0 = 3'h0;
  localparam logic [2:0] COMP_PCT1 = 3'h2;
  localparam logic [2:0] COMP_PCT2 = 3'h4;
  localparam logic [2:0] COMP_PCT3 = 3'h5;

  typedef enum logic [1:0] {PIN_PULSE, PIN_LEVEL, PIN_INT, PIN_RSVD} rpmc_pin_func_t;
  typedef enum logic [1:0] {MODE_REALTIME, MODE_SEQ, MODE_DIAG, MODE_CAL} rpmc_mode_t;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WBYTE, I2C_WACK, I2C_RBYTE, I2C_RACK
  } rpmc_i2c_state_t;
endpackage

/* rpmc_period_if.sv */
`timescale 1ns/1ps
interface rpmc_period_if;
  logic       period_edge;
  logic       playing;
  logic       avg_dis;
  logic [9:0] period;
  logic       period_upd;
  modport meas (input period_edge, input playing, input avg_dis,
                output period, output period_upd);
  modport core (output period_edge, output playing, output avg_dis,
                input period, input period_upd);
endinterface

/* rpmc_period_meas.sv */
`timescale 1ns/1ps
module rpmc_period_meas (
  input wire logic clk_i,
  input wire logic rst_i,
  rpmc_period_if.meas pif
);
  logic [15:0] acc_ff;
  logic [15:0] acc_sum;
  logic        tick;
  logic [9:0]  cnt_ff;
  logic        first_ff;
  logic [9:0]  hist_ff [rpmc_pkg::AVG_DEPTH];
  logic [11:0] sum_new;
  logic [9:0]  per_ff;
  logic        upd_ff;
  logic        take;
  logic [12:0] gap_ff;

  // Step timer in ns, restarted at each period boundary
  assign acc_sum = acc_ff + rpmc_pkg::CLK_NS_W;
  assign tick    = acc_sum >= rpmc_pkg::STEP_NS_W;
  assign take    = pif.period_edge && pif.playing && !first_ff;
  assign sum_new = {2'b00, cnt_ff} + {2'b00, hist_ff[0]} + {2'b00, hist_ff[1]}
                 + {2'b00, hist_ff[2]};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_ff <= 16'h0000;
    end else if (!pif.playing || pif.period_edge) begin
      acc_ff <= 16'h0000;
    end else if (tick) begin
      acc_ff <= acc_sum - rpmc_pkg::STEP_NS_W;
    end else begin
      acc_ff <= acc_sum;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff   <= 10'h000;
      first_ff <= 1'b1;
    end else if (!pif.playing) begin
      cnt_ff   <= 10'h000;
      first_ff <= 1'b1;
    end else if (pif.period_edge) begin
      cnt_ff   <= 10'h000;
      first_ff <= 1'b0;
    end else if (tick && cnt_ff != rpmc_pkg::PER_MAX) begin
      cnt_ff <= cnt_ff + 10'h001;
    end
  end

  // Cycles since the last step tick, for the step checks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_ff <= 13'h0000;
    end else if (!pif.playing || pif.period_edge || tick) begin
      gap_ff <= 13'h0000;
    end else begin
      gap_ff <= gap_ff + 13'h0001;
    end
  end

  // History preloaded with zero, newest in slot 0
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < rpmc_pkg::AVG_DEPTH; i++) begin
        hist_ff[i] <= rpmc_pkg::PER_RST;
      end
    end else if (take) begin
      hist_ff[0] <= cnt_ff;
      for (int i = 1; i < rpmc_pkg::AVG_DEPTH; i++) begin
        hist_ff[i] <= hist_ff[i-1];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_ff <= rpmc_pkg::PER_RST;
      upd_ff <= 1'b0;
    end else begin
      upd_ff <= take;
      if (take) begin
        per_ff <= pif.avg_dis ? cnt_ff : sum_new[rpmc_pkg::AVG_SHIFT +: 10];
      end
    end
  end

  assign pif.period     = per_ff;
  assign pif.period_upd = upd_ff;

  a_tick_gap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick |-> gap_ff == 13'(rpmc_pkg::STEP_CYCLES - 1))
    else $error("period step tick not one step after the last");
  a_tick_max: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pif.playing |-> gap_ff < 13'(rpmc_pkg::STEP_CYCLES))
    else $error("period step tick missing for a whole step");
  a_avg_mean: assert property (
    @(posedge clk_i) disable iff (rst_i)
    take && !pif.avg_dis && cnt_ff == hist_ff[0] && cnt_ff == hist_ff[1]
    && cnt_ff == hist_ff[2] |=> per_ff == $past(cnt_ff))
    else $error("mean of equal periods differs from the period");
endmodule

/* rpmc_ctrl.sv */
`timescale 1ns/1ps
module rpmc_ctrl #(
  parameter logic [6:0] OWN_ADDR = 7'h2a
) (
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  // Serial register bus
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  // Trigger and interrupt pin
  input  wire logic       TRIG_I,
  output logic            TRIG_O,
  output logic            TRIG_OE_O,
  // Playback engine
  input  wire logic       PLAYING_I,
  input  wire logic       PERIOD_EDGE_I,
  input  wire logic       BUSY_I,
  input  wire logic       GO_I,
  input  wire logic [4:0] STATUS_I,
  output logic            START_O,
  output logic            STOP_O,
  output logic [1:0]      MODE_O,
  output logic [2:0]      COMP_PCT_O
);
  rpmc_period_if pif ();
  rpmc_pkg::rpmc_i2c_state_t state_ff;
  rpmc_pkg::rpmc_pin_func_t  func;
  logic       scl_q_ff;
  logic       sda_q_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic       first_ff;
  logic       rw_ff;
  logic       nack_ff;
  logic       sda_oe_ff;
  logic       sda_o_ff;
  logic [7:0] mask_ff;
  logic [5:0] hi_rsv_ff;
  logic [9:0] per_ff;
  logic [7:0] ctrl_ff;
  logic       lock_ff;
  logic       play_q_ff;
  logic       trig_q_ff;
  logic       go_q_ff;
  logic       start_ff;
  logic       stop_ff;
  logic       trig_oe_ff;
  logic       trig_o_ff;
  logic [2:0] comp_ff;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       addr_hit;
  logic       rd_stb;
  logic       wr_stb;
  logic       abort;
  logic       play_end;
  logic [7:0] rd_data;

  assign pif.period_edge = PERIOD_EDGE_I;
  assign pif.playing     = PLAYING_I;
  assign pif.avg_dis     = ctrl_ff[rpmc_pkg::CTRL_AVG_BIT];

  rpmc_period_meas u_meas (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .pif   (pif.meas)
  );

  assign func     = rpmc_pkg::rpmc_pin_func_t'(ctrl_ff[rpmc_pkg::CTRL_FUNC_LSB +: 2]);
  assign scl_rise = SCL_I && !scl_q_ff;
  assign scl_fall = !SCL_I && scl_q_ff;
  assign start_c  = SCL_I && scl_q_ff && sda_q_ff && !SDA_I;
  assign stop_c   = SCL_I && scl_q_ff && !sda_q_ff && SDA_I;
  assign addr_hit = (sh_ff[7:1] == OWN_ADDR)
                 || (ctrl_ff[rpmc_pkg::CTRL_GC_BIT] && sh_ff[7:1] == rpmc_pkg::GROUP_ADDR);
  assign rd_stb   = scl_fall && ((state_ff == rpmc_pkg::I2C_AACK && rw_ff)
                 || (state_ff == rpmc_pkg::I2C_RACK && !nack_ff));
  assign wr_stb   = scl_fall && state_ff == rpmc_pkg::I2C_WBYTE
                 && cnt_ff == rpmc_pkg::BITS_PER_BYTE && !first_ff;
  assign abort    = wr_stb && ptr_ff == rpmc_pkg::REG_CTRL && BUSY_I
                 && sh_ff[3:0] != ctrl_ff[3:0];
  assign play_end = play_q_ff && !PLAYING_I;

  always_comb begin
    case (ptr_ff)
      rpmc_pkg::REG_MASK:   rd_data = mask_ff;
      rpmc_pkg::REG_PER_HI: rd_data = {hi_rsv_ff, per_ff[9:8]};
      rpmc_pkg::REG_PER_LO: rd_data = per_ff[7:0];
      rpmc_pkg::REG_CTRL:   rd_data = ctrl_ff;
      default:              rd_data = 8'h00;
    endcase
  end

  // Bus target engine
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_q_ff  <= 1'b1;
      sda_q_ff  <= 1'b1;
      state_ff  <= rpmc_pkg::I2C_IDLE;
      cnt_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      tx_ff     <= 8'h00;
      ptr_ff    <= 8'h00;
      first_ff  <= 1'b0;
      rw_ff     <= 1'b0;
      nack_ff   <= 1'b0;
      sda_oe_ff <= 1'b0;
      sda_o_ff  <= 1'b0;
    end else begin
      scl_q_ff <= SCL_I;
      sda_q_ff <= SDA_I;
      if (start_c) begin
        state_ff  <= rpmc_pkg::I2C_ADDR;
        cnt_ff    <= 4'h0;
        sda_oe_ff <= 1'b0;
      end else if (stop_c) begin
        state_ff  <= rpmc_pkg::I2C_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        sh_ff   <= {sh_ff[6:0], SDA_I};
        nack_ff <= SDA_I;
        if (cnt_ff != rpmc_pkg::BITS_PER_BYTE) begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end else if (scl_fall) begin
        case (state_ff)
          rpmc_pkg::I2C_IDLE: begin
            state_ff <= rpmc_pkg::I2C_IDLE;
          end
          rpmc_pkg::I2C_ADDR: begin
            if (cnt_ff == rpmc_pkg::BITS_PER_BYTE) begin
              if (addr_hit) begin
                rw_ff     <= sh_ff[0];
                sda_oe_ff <= 1'b1;
                state_ff  <= rpmc_pkg::I2C_AACK;
              end else begin
                state_ff <= rpmc_pkg::I2C_IDLE;
              end
            end
          end
          rpmc_pkg::I2C_WBYTE: begin
            if (cnt_ff == rpmc_pkg::BITS_PER_BYTE) begin
              sda_oe_ff <= 1'b1;
              state_ff  <= rpmc_pkg::I2C_WACK;
              first_ff  <= 1'b0;
              ptr_ff    <= first_ff ? sh_ff : ptr_ff + 8'h01;
            end
          end
          rpmc_pkg::I2C_WACK: begin
            sda_oe_ff <= 1'b0;
            cnt_ff    <= 4'h0;
            state_ff  <= rpmc_pkg::I2C_WBYTE;
          end
          rpmc_pkg::I2C_RBYTE: begin
            if (cnt_ff == rpmc_pkg::BITS_PER_BYTE) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= rpmc_pkg::I2C_RACK;
            end else if (cnt_ff != 4'h0) begin
              tx_ff     <= {tx_ff[6:0], 1'b0};
              sda_oe_ff <= !tx_ff[6];
            end
          end
          rpmc_pkg::I2C_AACK, rpmc_pkg::I2C_RACK: begin
            cnt_ff <= 4'h0;
            if (rd_stb) begin
              tx_ff     <= rd_data;
              sda_oe_ff <= !rd_data[7];
              ptr_ff    <= ptr_ff + 8'h01;
              state_ff  <= rpmc_pkg::I2C_RBYTE;
            end else if (state_ff == rpmc_pkg::I2C_AACK) begin
              sda_oe_ff <= 1'b0;
              first_ff  <= 1'b1;
              state_ff  <= rpmc_pkg::I2C_WBYTE;
            end else begin
              state_ff <= rpmc_pkg::I2C_IDLE;
            end
          end
          default: begin
            state_ff <= rpmc_pkg::I2C_IDLE;
          end
        endcase
      end
    end
  end

  // Writable registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mask_ff   <= rpmc_pkg::MASK_RST;
      hi_rsv_ff <= rpmc_pkg::HI_RSV_RST;
      ctrl_ff   <= rpmc_pkg::CTRL_RST;
    end else if (wr_stb) begin
      case (ptr_ff)
        rpmc_pkg::REG_MASK:   mask_ff <= sh_ff;
        rpmc_pkg::REG_PER_HI: hi_rsv_ff <= sh_ff[7:2];
        rpmc_pkg::REG_CTRL:   ctrl_ff <= sh_ff;
        default:              mask_ff <= mask_ff;
      endcase
    end
  end

  // Period readout with read-order lock; lock set wins over release
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      per_ff    <= rpmc_pkg::PER_RST;
      lock_ff   <= 1'b0;
      play_q_ff <= 1'b0;
    end else begin
      play_q_ff <= PLAYING_I;
      // No update in the cycle the upper byte is taken, so the pair matches
      if (pif.period_upd && PLAYING_I && !lock_ff
          && !(rd_stb && ptr_ff == rpmc_pkg::REG_PER_HI)) begin
        per_ff <= pif.period;
      end
      if (rd_stb && ptr_ff == rpmc_pkg::REG_PER_HI) begin
        lock_ff <= 1'b1;
      end else if ((rd_stb && ptr_ff == rpmc_pkg::REG_PER_LO) || play_end) begin
        lock_ff <= 1'b0;
      end
    end
  end

  // Process launch, pin function and compensation
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      trig_q_ff  <= 1'b0;
      go_q_ff    <= 1'b0;
      start_ff   <= 1'b0;
      stop_ff    <= 1'b0;
      trig_oe_ff <= 1'b0;
      trig_o_ff  <= 1'b0;
      comp_ff    <= rpmc_pkg::COMP_PCT0;
    end else begin
      trig_q_ff  <= TRIG_I;
      go_q_ff    <= GO_I;
      start_ff   <= 1'b0;
      stop_ff    <= 1'b0;
      trig_oe_ff <= func == rpmc_pkg::PIN_INT && |(STATUS_I & ~mask_ff[4:0]);
      if (abort) begin
        stop_ff <= 1'b1;
      end else begin
        case (func)
          rpmc_pkg::PIN_PULSE: begin
            start_ff <= (TRIG_I && !trig_q_ff) || (GO_I && !go_q_ff);
            stop_ff  <= !GO_I && go_q_ff;
          end
          rpmc_pkg::PIN_LEVEL: begin
            start_ff <= TRIG_I && !trig_q_ff;
            stop_ff  <= !TRIG_I && trig_q_ff;
          end
          rpmc_pkg::PIN_INT: begin
            start_ff <= GO_I && !go_q_ff;
            stop_ff  <= !GO_I && go_q_ff;
          end
          default: begin
            start_ff <= 1'b0;
          end
        endcase
      end
      case (ctrl_ff[rpmc_pkg::CTRL_COMP_LSB +: 2])
        2'h0:    comp_ff <= rpmc_pkg::COMP_PCT0;
        2'h1:    comp_ff <= rpmc_pkg::COMP_PCT1;
        2'h2:    comp_ff <= rpmc_pkg::COMP_PCT2;
        default: comp_ff <= rpmc_pkg::COMP_PCT3;
      endcase
    end
  end

  assign SDA_O      = sda_o_ff;
  assign SDA_OE_O   = sda_oe_ff;
  assign TRIG_O     = trig_o_ff;
  assign TRIG_OE_O  = trig_oe_ff;
  assign START_O    = start_ff;
  assign STOP_O     = stop_ff;
  assign MODE_O     = ctrl_ff[rpmc_pkg::CTRL_MODE_LSB +: 2];
  assign COMP_PCT_O = comp_ff;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_lock_set: assert property (
    rd_stb && ptr_ff == rpmc_pkg::REG_PER_HI |=> lock_ff)
    else $error("upper byte read did not lock the period");
  a_lock_freeze: assert property (
    lock_ff |=> $stable(per_ff))
    else $error("period changed while locked");
  a_lock_release: assert property (
    lock_ff && play_end && !(rd_stb && ptr_ff == rpmc_pkg::REG_PER_HI) |=> !lock_ff)
    else $error("lock kept after waveform end");
  a_group_call: assert property (
    scl_fall && state_ff == rpmc_pkg::I2C_ADDR && cnt_ff == rpmc_pkg::BITS_PER_BYTE
    && ctrl_ff[rpmc_pkg::CTRL_GC_BIT] && sh_ff[7:1] == rpmc_pkg::GROUP_ADDR
    |=> state_ff == rpmc_pkg::I2C_AACK && SDA_OE_O)
    else $error("group call address not acknowledged");
  a_level_nogo: assert property (
    func == rpmc_pkg::PIN_LEVEL && TRIG_I == trig_q_ff && !abort |=> !START_O && !STOP_O)
    else $error("launch bit acted in level mode");
  a_int_off: assert property (
    func != rpmc_pkg::PIN_INT |=> !TRIG_OE_O)
    else $error("pin driven outside interrupt mode");
  a_int_mask: assert property (
    $past(func) == rpmc_pkg::PIN_INT |-> TRIG_OE_O
    == $past(|(STATUS_I & ~mask_ff[4:0])))
    else $error("interrupt pin does not follow masked status");
  a_abort_stop: assert property (
    abort |=> STOP_O && !START_O ##1 !STOP_O)
    else $error("function or mode change did not abort");
  a_comp_map: assert property (
    ctrl_ff[5:4] == 2'h3 ##1 ctrl_ff[5:4] == 2'h3 |-> COMP_PCT_O == rpmc_pkg::COMP_PCT3)
    else $error("compensation code wrong");

  c_lock_cycle: cover property (lock_ff ##[1:1000] !lock_ff);
  c_group_call: cover property (state_ff == rpmc_pkg::I2C_AACK && ctrl_ff[7]);
  c_int_pin: cover property ($rose(TRIG_OE_O));
  c_abort: cover property (abort);
endmodule

/* rpmc_host.sv */
`timescale 1ns/1ps
module rpmc_host (
  // Clock and bus lines
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Each half of an SCL period lasts 4 clocks
  task automatic bit_io(input logic b, output logic r);
    scl_o <= 1'b0;
    tick(2);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
  endtask

  // Start or repeated start when s is 1, stop when s is 0
  task automatic cond(input logic s);
    scl_o <= 1'b0;
    tick(2);
    sda_o <= s;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_o <= ~s;
    tick(2);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] r,
                         output logic a);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(ai, a);
  endtask

  // Write one byte, or read n bytes in rising address order
  task automatic access(input logic [6:0] a, input logic [7:0] p, input logic wr,
                        input logic [7:0] wd, input int n, output logic [15:0] rd,
                        output logic nak);
    logic [7:0] b;
    logic       k;
    rd = 16'h0000;
    cond(1'b1);
    byte_io({a, 1'b0}, 1'b1, b, nak);
    if (nak === 1'b0) begin
      byte_io(p, 1'b1, b, k);
      if (wr) begin
        byte_io(wd, 1'b1, b, k);
      end else begin
        cond(1'b1);
        byte_io({a, 1'b1}, 1'b1, b, k);
        for (int j = 0; j < n; j++) begin
          byte_io(8'hff, (j == n - 1), b, k);
          rd = {rd[7:0], b};
        end
      end
    end
    cond(1'b0);
  endtask
endmodule

/* rpmc_ctrl_test.sv */
`timescale 1ns/1ps
module rpmc_ctrl_test;
  // Arbitrary own bus address
  localparam logic [6:0] own_addr = 7'h2a;
  // One period count is 24.39 us, 4878 clocks
  localparam int step = 4878;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        trig_drv = 1'b0;
  logic        playing = 1'b0;
  logic        edge_p = 1'b0;
  logic        busy = 1'b0;
  logic        go = 1'b0;
  logic [4:0]  status = 5'h00;
  logic        scl, host_sda, sda_o, sda_oe, trig_o, trig_oe, start_p, stop_p, nak;
  logic [1:0]  mode;
  logic [2:0]  comp;
  logic [15:0] rdv;
  logic [2:0]  comp_tab [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
  int          miscompares = 0;
  int          num_checks = 0;
  int          n_start = 0;
  int          n_stop = 0;
  int          s_mark, p_mark;
  // Both lines are open drain with pull-ups
  wire         sda_w = host_sda & ~sda_oe;
  wire         trig_w = trig_drv & ~trig_oe;

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (start_p === 1'b1) n_start++;
    if (stop_p === 1'b1) n_stop++;
  end

  rpmc_ctrl #(.OWN_ADDR(own_addr)) i_dut (
    .CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .TRIG_I(trig_w), .TRIG_O(trig_o), .TRIG_OE_O(trig_oe), .PLAYING_I(playing),
    .PERIOD_EDGE_I(edge_p), .BUSY_I(busy), .GO_I(go), .STATUS_I(status),
    .START_O(start_p), .STOP_O(stop_p), .MODE_O(mode), .COMP_PCT_O(comp));

  rpmc_host i_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    i_host.access(own_addr, r, 1'b1, d, 0, rdv, nak);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] r, input int n);
    i_host.access(a, r, 1'b0, 8'h00, n, rdv, nak);
  endtask

  task automatic rd_chk(input logic [7:0] r, input int n, input logic [15:0] e);
    rd(own_addr, r, n);
    check(rdv, e);
  endtask

  task automatic mark();
    s_mark = n_start;
    p_mark = n_stop;
  endtask

  task automatic cnt_chk(input int es, input int ep);
    check(16'(n_start - s_mark), 16'(es));
    check(16'(n_stop - p_mark), 16'(ep));
  endtask

  // Drive pin and launch bit, then count pulses
  task automatic pin(input logic t, input logic g, input int es, input int ep);
    mark();
    trig_drv <= t;
    go <= g;
    tick(6);
    cnt_chk(es, ep);
  endtask

  task automatic pulse_after(input int g);
    tick(g);
    edge_p <= 1'b1;
    tick(1);
    edge_p <= 1'b0;
    tick(4);
  endtask

  // Tests need about 70000 clocks, limit at 90000
  initial begin
    #450000;
    miscompares++;
    results();
  end

  initial begin
    tick(16);
    rst <= 1'b0;
    tick(2);
    rd_chk(8'h02, 1, 16'h0018);
    rd_chk(8'h07, 1, 16'h0044);
    rd_chk(8'h05, 2, 16'h0000);
    check(16'(mode), 16'h0000);
    check(16'(comp), 16'h0000);
    check(16'({sda_o, trig_o}), 16'h0000);
    wr(8'h05, 8'hff);
    rd_chk(8'h05, 2, 16'hfc00);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h55);
    rd_chk(8'h06, 1, 16'h0000);
    rd_chk(8'h10, 1, 16'h0000);
    rd(7'h2b, 8'h07, 1);
    check(16'(nak), 16'h0001);
    rd(rpmc_pkg::GROUP_ADDR, 8'h07, 1);
    check(16'(nak), 16'h0001);
    wr(8'h07, 8'hc4);
    rd(rpmc_pkg::GROUP_ADDR, 8'h07, 1);
    check({rdv[14:0], nak}, 16'h0188);
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, {2'b01, i[1:0], 2'b01, i[1:0]});
      check(16'(comp), 16'(comp_tab[i]));
      check(16'(mode), 16'(i));
    end
    wr(8'h07, 8'h04);
    playing <= 1'b1;
    pulse_after(4);
    pulse_after(4 * step + 976);
    rd_chk(8'h05, 2, 16'h0001);
    wr(8'h07, 8'h44);
    pulse_after(2 * step + 976);
    rd_chk(8'h05, 2, 16'h0002);
    rd_chk(8'h05, 1, 16'h0000);
    pulse_after(step + 976);
    rd_chk(8'h06, 1, 16'h0002);
    pulse_after(step + 976);
    rd_chk(8'h06, 1, 16'h0001);
    rd_chk(8'h05, 1, 16'h0000);
    playing <= 1'b0;
    tick(4);
    playing <= 1'b1;
    pulse_after(4);
    pulse_after(3 * step + 976);
    rd_chk(8'h06, 1, 16'h0003);
    pin(1'b0, 1'b1, 0, 0);
    pin(1'b1, 1'b1, 1, 0);
    pin(1'b0, 1'b0, 0, 1);
    wr(8'h07, 8'h40);
    pin(1'b0, 1'b1, 1, 0);
    pin(1'b0, 1'b0, 0, 1);
    pin(1'b1, 1'b0, 1, 0);
    pin(1'b0, 1'b0, 0, 0);
    status <= 5'h01;
    tick(3);
    check(16'(trig_oe), 16'h0000);
    wr(8'h07, 8'h48);
    check(16'(trig_oe), 16'h0001);
    status <= 5'h08;
    tick(3);
    check(16'(trig_oe), 16'h0000);
    status <= 5'h00;
    pin(1'b1, 1'b0, 0, 0);
    pin(1'b1, 1'b1, 1, 0);
    pin(1'b1, 1'b0, 0, 1);
    wr(8'h07, 8'h4c);
    pin(1'b0, 1'b1, 0, 0);
    busy <= 1'b1;
    mark();
    wr(8'h07, 8'h44);
    cnt_chk(0, 1);
    mark();
    wr(8'h07, 8'h45);
    cnt_chk(0, 1);
    mark();
    wr(8'h07, 8'h45);
    cnt_chk(0, 0);
    busy <= 1'b0;
    playing <= 1'b0;
    tick(4);
    rd_chk(8'h05, 2, 16'h0003);
    results();
  end
endmodule
